// ==== verilog/link_pkg.sv ====
// ****************************************************************
// Core-side register map
// ****************************************************************
package link_pkg;

  localparam int REG_COUNT = 16;
  localparam logic [3:0] IDX_LINK_CTRL = 4'h0;
  localparam logic [3:0] IDX_WAKE_SETTLE = 4'h1;
  localparam logic [3:0] IDX_LEN_LOW = 4'h2;
  localparam logic [3:0] IDX_LEN_MID = 4'h3;
  localparam logic [3:0] IDX_LEN_HIGH = 4'h4;

  localparam int BIT_DIRECT = 7;
  localparam int BIT_REMAP = 6;
  localparam int BIT_SLEEP_REQ = 5;
  localparam int BIT_SLEEP_CMD = 4;
  localparam int BIT_DOORBELL = 3;
  localparam int BIT_C2H_IRQ = 2;
  localparam int BIT_DB_MASK = 1;
  localparam int BIT_DONE = 0;
  localparam int BIT_PERM = 7;

  localparam logic [7:0] LINK_CTRL_RESET = 8'h00;
  localparam logic [3:0] SETTLE_RESET = 4'h0;
  localparam logic [22:0] LEN_RESET = 23'h00_0000;
  localparam logic PERM_RESET = 1'b0;

  // Settle step is 16 low-rate crystal periods
  localparam int SETTLE_SHIFT = 4;

  localparam logic [19:0] FLASH_BASE = 20'hE_0000;
  localparam logic [19:0] FLASH_TOP = 20'hF_FFFF;
  localparam logic [19:0] REMAP_LOW = 20'h0_8000;
  localparam logic [19:0] REMAP_HIGH = 20'h1_FFFF;

  // ****************************************************************
  // Controller AHB-Lite map
  // ****************************************************************
  localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
  localparam logic [7:0] HOST_CTRL_ADDR = 8'h04;
  localparam logic [7:0] CORE_ACC_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;

  localparam int CMD_CARD_PD = 0;
  localparam int CMD_PNP_SLEEP = 1;
  localparam int CMD_DOORBELL = 2;
  localparam int CMD_IRQ_ACK = 3;
  localparam int CMD_PD_CLEAR = 4;
  localparam int CMD_DIS_SLEEP = 5;
  localparam int ACC_WRITE_BIT = 16;
  localparam logic WAIT_HOLD_RESET = 1'b0;

  typedef enum logic [3:0] {
    PD_IDLE = 4'h1,
    PD_SLEEP = 4'h2,
    PD_SETTLE = 4'h4,
    PD_FINISH = 4'h8
  } pd_state_type;

endpackage

// ==== verilog/core_host_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface core_host_link_if;
  logic reg_req;
  logic reg_write;
  logic [3:0] reg_index;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic host_sleep_req;
  logic host_sleep_exit;
  logic host_doorbell_cmd;
  logic host_irq_ack;
  logic core_wait_hold;
  logic core_irq;
  logic host_irq;
  logic sleep_active;

  modport device (
    input reg_req,
    input reg_write,
    input reg_index,
    input reg_wdata,
    output reg_rdata,
    output reg_ack,
    input host_sleep_req,
    input host_sleep_exit,
    input host_doorbell_cmd,
    input host_irq_ack,
    input core_wait_hold,
    output core_irq,
    output host_irq,
    output sleep_active
  );

  modport ctrl (
    output reg_req,
    output reg_write,
    output reg_index,
    output reg_wdata,
    input reg_rdata,
    input reg_ack,
    output host_sleep_req,
    output host_sleep_exit,
    output host_doorbell_cmd,
    output host_irq_ack,
    output core_wait_hold,
    input core_irq,
    input host_irq,
    input sleep_active
  );
endinterface
`default_nettype wire

// ==== verilog/link_device.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_device (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic low_rate_crystal,
  input wire logic host_mem_cycle,
  input wire logic core_mem_valid,
  input wire logic [19:0] core_mem_addr,
  core_host_link_if.device link,
  output logic host_mem_direct,
  output logic host_mem_arb,
  output logic flash_select,
  output logic [16:0] flash_offset,
  output logic clock_buffer_off,
  output logic clock_buffer_settle
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic done_hold;
    logic [3:0] settle;
    logic perm;
    logic [22:0] len;
    logic lrc_meta;
    logic lrc_sync;
    logic lrc_prev;
    link_pkg::pd_state_type state;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic core_irq;
    logic host_irq;
    logic sleep_active;
    logic host_direct;
    logic host_arb;
    logic flash_sel;
    logic [16:0] flash_offset;
    logic buf_off;
    logic buf_settle;
  } dev_state_type;

  dev_state_type s_q;
  dev_state_type s_d;
  logic lrc_tick;
  logic reg_wr;
  logic ctrl_wr;
  logic [7:0] wd;
  logic in_base;
  logic in_remap;

  function automatic logic in_window(
    input logic [19:0] a,
    input logic [19:0] lo,
    input logic [19:0] hi
  );
    in_window = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [22:0] settle_span(input logic [3:0] c);
    settle_span = 23'(c) << link_pkg::SETTLE_SHIFT;
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Only the synchronised copy is edge-detected
  assign lrc_tick = s_q.lrc_sync & ~s_q.lrc_prev;
  // Register port carries core cycles only; host commands arrive on separate link signals
  assign reg_wr = link.reg_req & link.reg_write;
  assign ctrl_wr = reg_wr && (link.reg_index == link_pkg::IDX_LINK_CTRL);
  assign wd = link.reg_wdata;
  assign in_base = in_window(core_mem_addr, link_pkg::FLASH_BASE, link_pkg::FLASH_TOP);
  assign in_remap = s_q.ctrl[link_pkg::BIT_REMAP] &&
                    in_window(core_mem_addr, link_pkg::REMAP_LOW, link_pkg::REMAP_HIGH);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.reg_ack = 1'b0;
    s_d.lrc_meta = low_rate_crystal;
    s_d.lrc_sync = s_q.lrc_meta;
    s_d.lrc_prev = s_q.lrc_sync;

    case (s_q.state)
      link_pkg::PD_IDLE: begin
        // Length is taken as already loaded by firmware
        if (ctrl_wr && wd[link_pkg::BIT_SLEEP_CMD]) begin
          s_d.ctrl[link_pkg::BIT_SLEEP_CMD] = 1'b1;
          s_d.state = link_pkg::PD_SLEEP;
        end
      end
      link_pkg::PD_SLEEP, link_pkg::PD_SETTLE: begin
        if (s_q.perm) begin
          // Counts are ignored; only the host ends it
          if (link.host_sleep_exit) begin
            s_d.state = link_pkg::PD_FINISH;
          end
        end else if (s_q.len == 23'h0) begin
          s_d.state = link_pkg::PD_FINISH;
        end else begin
          if (lrc_tick) begin
            s_d.len = s_q.len - 23'h1;
          end
          // Settle starts so that it runs out with the length
          if (s_d.len <= settle_span(s_q.settle)) begin
            s_d.state = link_pkg::PD_SETTLE;
          end
        end
      end
      link_pkg::PD_FINISH: begin
        s_d.ctrl[link_pkg::BIT_SLEEP_CMD] = 1'b0;
        s_d.state = link_pkg::PD_IDLE;
      end
      default: begin
        s_d.state = link_pkg::PD_IDLE;
      end
    endcase

    // Clears first, so that a set in the same cycle wins
    if (link.host_irq_ack) begin
      s_d.ctrl[link_pkg::BIT_C2H_IRQ] = 1'b0;
    end

    if (reg_wr) begin
      case (link.reg_index)
        link_pkg::IDX_LINK_CTRL: begin
          s_d.ctrl[link_pkg::BIT_DIRECT] = wd[link_pkg::BIT_DIRECT];
          s_d.ctrl[link_pkg::BIT_REMAP] = wd[link_pkg::BIT_REMAP];
          s_d.ctrl[link_pkg::BIT_DB_MASK] = wd[link_pkg::BIT_DB_MASK];
          if (wd[link_pkg::BIT_SLEEP_REQ]) begin
            s_d.ctrl[link_pkg::BIT_SLEEP_REQ] = 1'b0;
          end
          if (wd[link_pkg::BIT_DOORBELL]) begin
            s_d.ctrl[link_pkg::BIT_DOORBELL] = 1'b0;
          end
          if (wd[link_pkg::BIT_C2H_IRQ]) begin
            s_d.ctrl[link_pkg::BIT_C2H_IRQ] = 1'b1;
          end
          // Writing one drops the flag and holds it until a zero
          if (wd[link_pkg::BIT_DONE]) begin
            s_d.ctrl[link_pkg::BIT_DONE] = 1'b0;
            s_d.done_hold = 1'b1;
          end else begin
            s_d.done_hold = 1'b0;
          end
        end
        link_pkg::IDX_WAKE_SETTLE: begin
          s_d.settle = wd[7:4];
        end
        link_pkg::IDX_LEN_LOW: begin
          s_d.len[7:0] = wd;
        end
        link_pkg::IDX_LEN_MID: begin
          s_d.len[15:8] = wd;
        end
        link_pkg::IDX_LEN_HIGH: begin
          s_d.perm = wd[link_pkg::BIT_PERM];
          s_d.len[22:16] = wd[6:0];
        end
        default: begin
        end
      endcase
    end

    // A held flag cannot be set again
    if ((s_q.state == link_pkg::PD_FINISH) && !s_d.done_hold) begin
      s_d.ctrl[link_pkg::BIT_DONE] = 1'b1;
    end
    if (link.host_sleep_req) begin
      s_d.ctrl[link_pkg::BIT_SLEEP_REQ] = 1'b1;
    end
    if (link.host_doorbell_cmd) begin
      s_d.ctrl[link_pkg::BIT_DOORBELL] = 1'b1;
    end

    // Reads return the value before any write of this cycle
    if (link.reg_req) begin
      s_d.reg_ack = 1'b1;
      case (link.reg_index)
        link_pkg::IDX_LINK_CTRL: s_d.reg_rdata = s_q.ctrl;
        link_pkg::IDX_WAKE_SETTLE: s_d.reg_rdata = {s_q.settle, 4'h0};
        link_pkg::IDX_LEN_LOW: s_d.reg_rdata = s_q.len[7:0];
        link_pkg::IDX_LEN_MID: s_d.reg_rdata = s_q.len[15:8];
        link_pkg::IDX_LEN_HIGH: s_d.reg_rdata = {s_q.perm, s_q.len[22:16]};
        default: s_d.reg_rdata = 8'h00;
      endcase
    end

    // ****************************************************************
    // Outputs, registered from the next state except the remap bit in flash select, taken from the current one
    // ****************************************************************
    s_d.core_irq = s_d.ctrl[link_pkg::BIT_SLEEP_REQ] |
                   (s_d.ctrl[link_pkg::BIT_DOORBELL] & s_d.ctrl[link_pkg::BIT_DB_MASK]) |
                   s_d.ctrl[link_pkg::BIT_DONE];
    s_d.host_irq = s_d.ctrl[link_pkg::BIT_C2H_IRQ] & ~link.core_wait_hold;
    s_d.sleep_active = (s_d.state != link_pkg::PD_IDLE);
    s_d.buf_off = (s_d.state == link_pkg::PD_SLEEP);
    s_d.buf_settle = (s_d.state == link_pkg::PD_SETTLE);
    // Direct mode is only safe while the core is halted
    s_d.host_direct = host_mem_cycle & s_d.ctrl[link_pkg::BIT_DIRECT];
    s_d.host_arb = host_mem_cycle & ~s_d.ctrl[link_pkg::BIT_DIRECT];
    // Both windows share the low 17 address bits of flash
    s_d.flash_sel = core_mem_valid & (in_base | in_remap);
    s_d.flash_offset = core_mem_addr[16:0];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl <= link_pkg::LINK_CTRL_RESET;
      s_q.settle <= link_pkg::SETTLE_RESET;
      s_q.len <= link_pkg::LEN_RESET;
      s_q.perm <= link_pkg::PERM_RESET;
      s_q.state <= link_pkg::PD_IDLE;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign link.reg_rdata = s_q.reg_rdata;
  assign link.reg_ack = s_q.reg_ack;
  assign link.core_irq = s_q.core_irq;
  assign link.host_irq = s_q.host_irq;
  assign link.sleep_active = s_q.sleep_active;
  assign host_mem_direct = s_q.host_direct;
  assign host_mem_arb = s_q.host_arb;
  assign flash_select = s_q.flash_sel;
  assign flash_offset = s_q.flash_offset;
  assign clock_buffer_off = s_q.buf_off;
  assign clock_buffer_settle = s_q.buf_settle;

endmodule
`default_nettype wire

// ==== verilog/link_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module link_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  core_host_link_if.ctrl link
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic ready;
    logic busy;
    logic [7:0] rdata;
    logic reg_req;
    logic reg_write;
    logic [3:0] reg_index;
    logic [7:0] reg_wdata;
    logic sleep_req;
    logic sleep_exit;
    logic doorbell;
    logic irq_ack;
    logic wait_hold;
  } ctrl_state_type;

  ctrl_state_type s_q;
  ctrl_state_type s_d;
  logic addr_phase;

  // Only word transfers are used; hsize is not decoded
  assign addr_phase = hsel & hready & htrans[1];

  always_comb begin
    s_d = s_q;
    s_d.ph_write = 1'b0;
    s_d.reg_req = 1'b0;
    s_d.sleep_req = 1'b0;
    s_d.sleep_exit = 1'b0;
    s_d.doorbell = 1'b0;
    s_d.irq_ack = 1'b0;

    if (link.reg_ack) begin
      s_d.busy = 1'b0;
      s_d.rdata = link.reg_rdata;
    end

    // ****************************************************************
    // Write data phase
    // ****************************************************************
    if (s_q.ph_write) begin
      case (s_q.ph_addr)
        link_pkg::HOST_CMD_ADDR: begin
          s_d.sleep_req = hwdata[link_pkg::CMD_CARD_PD] | hwdata[link_pkg::CMD_PNP_SLEEP];
          s_d.sleep_exit = hwdata[link_pkg::CMD_PD_CLEAR] | hwdata[link_pkg::CMD_DIS_SLEEP];
          s_d.doorbell = hwdata[link_pkg::CMD_DOORBELL];
          s_d.irq_ack = hwdata[link_pkg::CMD_IRQ_ACK];
        end
        link_pkg::HOST_CTRL_ADDR: begin
          s_d.wait_hold = hwdata[0];
        end
        link_pkg::CORE_ACC_ADDR: begin
          // One core cycle at a time; a write while busy is dropped
          if (!s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.reg_req = 1'b1;
            s_d.reg_write = hwdata[link_pkg::ACC_WRITE_BIT];
            s_d.reg_index = hwdata[11:8];
            s_d.reg_wdata = hwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // Address phase
    // ****************************************************************
    if (addr_phase) begin
      if (hwrite) begin
        s_d.ph_write = 1'b1;
        s_d.ph_addr = haddr[7:0];
      end else begin
        case (haddr[7:0])
          link_pkg::HOST_CTRL_ADDR: s_d.hrdata = {31'h0000_0000, s_q.wait_hold};
          link_pkg::STATUS_ADDR: s_d.hrdata = {20'h0_0000, link.sleep_active, link.host_irq,
                                               link.core_irq, s_q.busy, s_q.rdata};
          default: s_d.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
      s_q.wait_hold <= link_pkg::WAIT_HOLD_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.ready;
  assign hrdata = s_q.hrdata;
  assign hresp = 1'b0;
  assign link.reg_req = s_q.reg_req;
  assign link.reg_write = s_q.reg_write;
  assign link.reg_index = s_q.reg_index;
  assign link.reg_wdata = s_q.reg_wdata;
  assign link.host_sleep_req = s_q.sleep_req;
  assign link.host_sleep_exit = s_q.sleep_exit;
  assign link.host_doorbell_cmd = s_q.doorbell;
  assign link.host_irq_ack = s_q.irq_ack;
  assign link.core_wait_hold = s_q.wait_hold;

endmodule
`default_nettype wire

// ==== verif/link_checker_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Link handshake and interrupt checks
// ********
module link_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [3:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic host_sleep_req,
  input wire logic host_irq_ack,
  input wire logic core_wait_hold,
  input wire logic core_irq,
  input wire logic host_irq,
  input wire logic sleep_active
);
  logic wr;
  assign wr = reg_req & reg_write;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_req;
    reg_req;
  endsequence
  // Start only from idle, so a write during a run is not mistaken for a new start
  sequence s_cmd_wr;
    wr && reg_index == 4'h0 && reg_wdata[4] && !sleep_active;
  endsequence
  a_ack_next: assert property (s_req |=> reg_ack) else $error("ack missing");
  a_ack_single: assert property (reg_ack |=> !reg_ack) else $error("ack too long");
  a_ack_cause: assert property (reg_ack |-> $past(reg_req)) else $error("ack without request");
  a_rdata_hold: assert property ($changed(reg_rdata) |-> reg_ack) else $error("read data moved");
  a_sleep_req_irq: assert property (host_sleep_req |-> ##[1:2] core_irq) else $error("no core irq");
  a_core_irq_drop: assert property ($fell(core_irq) |-> $past(wr)) else $error("irq dropped");
  a_ack_clears: assert property (host_irq_ack && !wr |-> ##1 !host_irq) else $error("host irq kept");
  a_wait_blocks: assert property (core_wait_hold [*3] |-> !host_irq) else $error("host irq not held");
  a_sleep_start: assert property (s_cmd_wr |-> ##[1:4] sleep_active) else $error("sleep not started");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ********
// Bench for controller and device joined by the link
// ********
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic low_rate_crystal = 1'b0;
  logic host_mem_cycle = 1'b0;
  logic core_mem_valid = 1'b0;
  logic [19:0] core_mem_addr = 20'h0_0000;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [16:0] flash_offset;
  logic host_mem_direct;
  logic host_mem_arb;
  logic flash_select;
  logic clock_buffer_off;
  logic clock_buffer_settle;
  logic [31:0] s;
  logic [7:0] v;
  int error_cnt = 0;
  int checks = 0;
  always #25 hclk = ~hclk;
  core_host_link_if u_core_host_link_if ();
  link_ctrl u_link_ctrl (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(u_core_host_link_if.ctrl));
  link_device u_link_device (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .low_rate_crystal(low_rate_crystal), .host_mem_cycle(host_mem_cycle), .core_mem_valid(core_mem_valid),
    .core_mem_addr(core_mem_addr), .link(u_core_host_link_if.device), .host_mem_direct(host_mem_direct),
    .host_mem_arb(host_mem_arb), .flash_select(flash_select), .flash_offset(flash_offset),
    .clock_buffer_off(clock_buffer_off), .clock_buffer_settle(clock_buffer_settle));
  link_checker u_link_checker (.hclk(hclk), .hresetn(hresetn), .reg_req(u_core_host_link_if.reg_req),
    .reg_write(u_core_host_link_if.reg_write), .reg_index(u_core_host_link_if.reg_index),
    .reg_wdata(u_core_host_link_if.reg_wdata), .reg_rdata(u_core_host_link_if.reg_rdata),
    .reg_ack(u_core_host_link_if.reg_ack), .host_sleep_req(u_core_host_link_if.host_sleep_req),
    .host_irq_ack(u_core_host_link_if.host_irq_ack), .core_wait_hold(u_core_host_link_if.core_wait_hold),
    .core_irq(u_core_host_link_if.core_irq), .host_irq(u_core_host_link_if.host_irq),
    .sleep_active(u_core_host_link_if.sleep_active));

  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    ck("hresp", 32'h0000_0000, 32'(hresp));
    if (n >= 50) begin
      $display("mismatch hready exp 1 got 0");
      error_cnt++;
      end_sim();
    end
  endtask

  // Settle a few cycles first: status samples at its address edge
  task automatic stat;
    repeat (3) @(posedge hclk);
    ahb(1'b0, link_pkg::STATUS_ADDR, 32'h0000_0000, s);
  endtask

  task automatic hc(input int b);
    ahb(1'b1, link_pkg::HOST_CMD_ADDR, 32'h0000_0001 << b, s);
  endtask

  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    ahb(1'b1, link_pkg::CORE_ACC_ADDR, {15'h0000, w, 4'h0, i, d}, s);
    do begin
      ahb(1'b0, link_pkg::STATUS_ADDR, 32'h0000_0000, s);
      n++;
    end while (s[8] !== 1'b0 && n < 20);
    if (n >= 20) begin
      $display("mismatch busy exp 0 got 1");
      error_cnt++;
      end_sim();
    end
    r = s[7:0];
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      low_rate_crystal <= 1'b1;
      repeat (5) @(posedge hclk);
      low_rate_crystal <= 1'b0;
      repeat (5) @(posedge hclk);
    end
  endtask

  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 4'(i), 8'h00, v);
      ck("reset value", 8'h00, v);
    end
    acc(1'b1, 4'h3, 8'h5A, v);
    acc(1'b1, 4'h4, 8'h35, v);
    acc(1'b1, 4'hA, 8'hFF, v);
    acc(1'b0, 4'h3, 8'h00, v);
    ck("len mid", 8'h5A, v);
    acc(1'b0, 4'h4, 8'h00, v);
    ck("len high", 8'h35, v);
    acc(1'b0, 4'hA, 8'h00, v);
    ck("unmapped", 8'h00, v);
    acc(1'b1, 4'h3, 8'h00, v);
    acc(1'b1, 4'h4, 8'h00, v);
  endtask

  task automatic t_door;
    hc(link_pkg::CMD_DOORBELL);
    acc(1'b1, 4'h0, 8'h00, v);
    acc(1'b0, 4'h0, 8'h00, v);
    ck("doorbell", 8'h08, v);
    stat;
    ck("masked irq", 8'h00, 8'(s[9]));
    acc(1'b1, 4'h0, 8'h02, v);
    stat;
    ck("unmasked irq", 8'h01, 8'(s[9]));
    acc(1'b1, 4'h0, 8'h0A, v);
    acc(1'b0, 4'h0, 8'h00, v);
    ck("doorbell clear", 8'h02, v);
    acc(1'b1, 4'h0, 8'h00, v);
  endtask

  task automatic t_sreq;
    for (int i = 0; i < 2; i++) begin
      hc(i == 0 ? link_pkg::CMD_CARD_PD : link_pkg::CMD_PNP_SLEEP);
      stat;
      ck("sleep irq", 8'h01, 8'(s[9]));
      acc(1'b1, 4'h0, 8'h00, v);
      acc(1'b0, 4'h0, 8'h00, v);
      ck("sleep req kept", 8'h20, v);
      acc(1'b1, 4'h0, 8'h20, v);
      acc(1'b0, 4'h0, 8'h00, v);
      ck("sleep req clear", 8'h00, v);
    end
  endtask

  task automatic t_c2h;
    acc(1'b1, 4'h0, 8'h04, v);
    stat;
    ck("host irq", 8'h01, 8'(s[10]));
    acc(1'b1, 4'h0, 8'h00, v);
    acc(1'b0, 4'h0, 8'h00, v);
    ck("c2h kept", 8'h04, v);
    ahb(1'b1, link_pkg::HOST_CTRL_ADDR, 32'h0000_0001, s);
    stat;
    ck("held irq", 8'h00, 8'(s[10]));
    ahb(1'b1, link_pkg::HOST_CTRL_ADDR, 32'h0000_0000, s);
    stat;
    ck("released irq", 8'h01, 8'(s[10]));
    hc(link_pkg::CMD_IRQ_ACK);
    stat;
    ck("acked irq", 8'h00, 8'(s[10]));
    acc(1'b0, 4'h0, 8'h00, v);
    ck("c2h clear", 8'h00, v);
  endtask

  task automatic t_map;
    logic [19:0] a [7] = '{20'h0_7FFF, 20'h0_8000, 20'h1_FFFF, 20'h2_0000, 20'hD_FFFF, 20'hE_0000, 20'hF_FFFF};
    logic [6:0] m [2] = '{7'b110_0000, 7'b110_0110};
    host_mem_cycle <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      // Core stays idle while the host may own memory
      core_mem_valid <= 1'b0;
      acc(1'b1, 4'h0, {r[0], r[0], 6'h00}, v);
      repeat (3) @(posedge hclk);
      ck("direct", 8'(r[0]), 8'(host_mem_direct));
      ck("arb", 8'(!r[0]), 8'(host_mem_arb));
      acc(1'b1, 4'h0, {1'b0, r[0], 6'h00}, v);
      core_mem_valid <= 1'b1;
      for (int i = 0; i < 7; i++) begin
        core_mem_addr <= a[i];
        repeat (3) @(posedge hclk);
        ck("flash", 8'(m[r][i]), 8'(flash_select));
        ck("offset", 32'(a[i][16:0]), 32'(flash_offset));
      end
    end
    acc(1'b1, 4'h0, 8'h00, v);
  endtask

  task automatic t_pd;
    acc(1'b1, 4'h1, 8'h10, v);
    acc(1'b0, 4'h1, 8'h00, v);
    ck("settle reg", 8'h10, v);
    acc(1'b1, 4'h2, 8'h14, v);
    acc(1'b1, 4'h0, 8'h10, v);
    stat;
    ck("active", 8'h01, 8'(s[11]));
    ck("buffer off", 8'h01, 8'(clock_buffer_off));
    tick(3);
    acc(1'b0, 4'h2, 8'h00, v);
    ck("len count", 8'h11, v);
    ck("no settle", 8'h00, 8'(clock_buffer_settle));
    tick(1);
    repeat (3) @(posedge hclk);
    ck("settle", 8'h01, 8'(clock_buffer_settle));
    acc(1'b0, 4'h0, 8'h00, v);
    ck("cmd running", 8'h10, v);
    tick(15);
    stat;
    ck("still active", 8'h01, 8'(s[11]));
    tick(1);
    acc(1'b0, 4'h0, 8'h00, v);
    ck("done", 8'h01, v);
    stat;
    ck("done irq", 8'h01, 8'(s[9]));
    ck("ended", 8'h00, 8'(s[11]));
    acc(1'b1, 4'h0, 8'h01, v);
    acc(1'b0, 4'h0, 8'h00, v);
    ck("done cleared", 8'h00, v);
  endtask

  // Each start write of 8'h11 also writes DONE as one, which holds it, so a finish must not set it
  task automatic t_perm;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 4'h2, 8'h05, v);
      acc(1'b1, 4'h4, 8'h80, v);
      acc(1'b1, 4'h0, 8'h11, v);
      tick(3);
      acc(1'b0, 4'h2, 8'h00, v);
      ck("frozen len", 8'h05, v);
      stat;
      ck("perm active", 8'h01, 8'(s[11]));
      hc(i == 0 ? link_pkg::CMD_PD_CLEAR : link_pkg::CMD_DIS_SLEEP);
      stat;
      ck("perm exit", 8'h00, 8'(s[11]));
      acc(1'b0, 4'h0, 8'h00, v);
      ck("done held", 8'h00, v);
    end
    acc(1'b1, 4'h0, 8'h00, v);
    acc(1'b1, 4'h4, 8'h00, v);
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_door();
    t_sreq();
    t_c2h();
    t_map();
    t_pd();
    t_perm();
    end_sim();
  end
endmodule
`default_nettype wire
